/* pcs_pkg.sv */
// Constants and types for the parameter command and save engine
package pcs_pkg;
   // ------------------------------------------------------------------
   // Register map (byte offsets) and field positions
   // ------------------------------------------------------------------
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_COPY = 4'h4;
   localparam logic [3:0] REG_CTRL = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;
   localparam int CTRL_RESET_BIT = 0;
   localparam int CTRL_BUSY_BIT = 0;
   localparam int ST_USER_ERR = 0;
   localparam int ST_PD_ERR = 1;
   localparam int ST_INVALID = 2;
   localparam int ST_FAIL = 3;
   localparam int ST_BANK = 4;
   localparam int ST_FILT = 5;
   localparam int ST_REINIT = 7;
   // ------------------------------------------------------------------
   // Command codes and copy-mode values
   // ------------------------------------------------------------------
   localparam logic [16:0] CODE_SAVE_SAFE = 17'h003e8;
   localparam logic [16:0] CODE_SAVE_ANY = 17'h003e9;
   localparam logic [16:0] CODE_DFLT_STD = 17'h004d1;
   localparam logic [16:0] CODE_DFLT_REG = 17'h004dc;
   localparam logic [16:0] CODE_NP_BASE = 17'h02af8;
   localparam logic [16:0] CODE_SHOW_NONDEF = 17'h02ee0;
   localparam logic [16:0] CODE_SHOW_DESTINATION_CLASH_TRIP = 17'h02ee1;
   localparam logic [16:0] NP_Z1 = 17'h0000a;
   localparam logic [16:0] NP_Z2 = 17'h00014;
   localparam logic [16:0] NP_Z3 = 17'h0001e;
   localparam logic [16:0] NP_SPAN = 17'h00028;
   localparam logic [2:0] COPY_CARD_LO = 3'h3;
   localparam logic [2:0] COPY_CARD_HI = 3'h4;
   // ------------------------------------------------------------------
   // Reset values and default voltages
   // ------------------------------------------------------------------
   localparam logic [16:0] CMD_RST = 17'h00000;
   localparam logic [2:0] COPY_RST = 3'h0;
   localparam logic [1:0] REINIT_RST = 2'h0;
   localparam logic [1:0] REINIT_SAVES = 2'h2;
   localparam logic [9:0] RAMP_V_REGIONAL = 10'h307;
   localparam logic [9:0] RATED_V_REGIONAL = 10'h1cc;
   localparam logic [9:0] RAMP_V_STD = 10'h2ee;
   localparam logic [9:0] RATED_V_STD = 10'h190;
   // ------------------------------------------------------------------
   // Enumerations
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {FILT_ALL = 2'h0, FILT_NONDEF = 2'h1, FILT_DESTINATION_CLASH_TRIP = 2'h2} pcs_filt_e;
   typedef enum logic [2:0] {
      JOB_PROBE = 3'h0, JOB_SAVE = 3'h1, JOB_LOAD_STD = 3'h2, JOB_LOAD_REG = 3'h3,
      JOB_NAMEPLATE = 3'h4, JOB_CARD = 3'h5
   } pcs_job_e;
   typedef enum logic [6:0] {
      ST_PROBE = 7'h01, ST_IDLE = 7'h02, ST_LOAD = 7'h04, ST_NP = 7'h08,
      ST_SAVE = 7'h10, ST_CARD = 7'h20, ST_MENU0 = 7'h40
   } pcs_state_e;
endpackage

/* pcs_engine.sv */
// Command decoder and two-bank save sequencer with Avalon-MM register access
`timescale 1ns/1ns
// What this block does
// - Successful reset-triggered action clears the command
// - Action that cannot start: command kept, no trip
// - Started action failing raises trip, command kept
// - Success clears command, copy-mode only below three
// - Copy-mode 1/2 with command: command only, both cleared
// - Copy-mode 3/4 adds card write per save, except keypad menu-0 saves
// - Commanded save stores power-down set too
// - Code 1000 needs healthy supply; 1001 always saves
// - Save duration varies; wait without timeout
// - Write inactive bank, switch after completion
// - Interrupted save flagged at power-up, old bank used
// - No valid stored data raises invalid-store trip
// - Keypad menu-0 saves write active bank directly
// - Save user set after defaults, and after nameplate with y=1
// - Card writes carry no bank protection
// - After module change, next two saves other than menu-0 saves clear first
// - Code 1233 loads standard defaults then saves
// - Code 1244 loads regional defaults, 775V/460V on 400V units
// - Code 110zy moves nameplate; z slot, y direction
// - Codes 12000/12001 choose the display filter
// - Filter codes act at once, others need reset
module pcs_engine (
   input wire logic clock,
   input wire logic reset,
   input wire logic [3:0] avm_address,
   input wire logic avm_read,
   input wire logic avm_write,
   input wire logic [31:0] avm_writedata,
   output logic [31:0] avm_readdata,
   output logic avm_waitrequest,
   input wire logic undervoltage_pin,
   input wire logic low_supply_pin,
   input wire logic drive_enabled_pin,
   input wire logic unit_400v_pin,
   input wire logic menu0_save_req,
   input wire logic module_change,
   input wire logic job_done,
   input wire logic job_fail,
   input wire logic [1:0] probe_bank_valid,
   input wire logic probe_newest_bank,
   input wire logic probe_torn_user,
   input wire logic probe_torn_pd,
   output logic job_req,
   output logic [2:0] job_code,
   output logic job_bank,
   output logic job_ps,
   output logic job_clear,
   output logic job_direct,
   output logic [1:0] job_slot,
   output logic job_dir,
   output logic [9:0] ramp_volts,
   output logic [9:0] rated_volts,
   output logic [1:0] display_filter,
   output logic active_bank,
   output logic user_save_error_trip,
   output logic powerdown_save_error_trip,
   output logic store_invalid_trip,
   output logic action_fail_trip
);
   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   pcs_pkg::pcs_state_e state_r, state_nxt;
   logic [3:0] sync1_r, sync2_r;
   logic supply_low, drive_enabled, unit_400v;
   logic [16:0] cmd_r;
   logic [2:0] copy_r;
   logic reset_req_r, menu0_pend_r;
   logic [1:0] reinit_r;
   logic wr_take, rd_take, idle, go, finish, fail, start_ps;
   logic [3:0] np;

   // Nameplate code decode: {valid, slot, direction}
   function automatic logic [3:0] np_decode(input logic [16:0] c);
      logic [16:0] off;
      logic [1:0] z;
      logic [16:0] y;
      off = c - pcs_pkg::CODE_NP_BASE;
      z = (off >= pcs_pkg::NP_Z3) ? 2'h3 : (off >= pcs_pkg::NP_Z2) ? 2'h2 :
          (off >= pcs_pkg::NP_Z1) ? 2'h1 : 2'h0;
      unique case (z)
         2'h3: y = off - pcs_pkg::NP_Z3;
         2'h2: y = off - pcs_pkg::NP_Z2;
         2'h1: y = off - pcs_pkg::NP_Z1;
         2'h0: y = off;
      endcase
      np_decode = {(c >= pcs_pkg::CODE_NP_BASE) && (off < pcs_pkg::NP_SPAN) && (y <= 17'h00001),
                   z, y[0]};
   endfunction

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   // Two stages on every supply and status pin
   always_ff @(posedge clock) begin
      if (reset) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
      end else begin
         sync1_r <= {unit_400v_pin, drive_enabled_pin, low_supply_pin, undervoltage_pin};
         sync2_r <= sync1_r;
      end
   end
   assign supply_low = sync2_r[0] | sync2_r[1];
   assign drive_enabled = sync2_r[2];
   assign unit_400v = sync2_r[3];

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   assign idle = (state_r == pcs_pkg::ST_IDLE);
   assign go = idle && reset_req_r;
   assign np = np_decode(cmd_r);
   assign wr_take = avm_write && !avm_waitrequest;
   assign rd_take = avm_read && avm_waitrequest;

   // Next state, success and failure of a command sequence
   always_comb begin
      state_nxt = state_r;
      finish = 1'b0;
      fail = 1'b0;
      start_ps = 1'b0;
      unique case (state_r)
         pcs_pkg::ST_PROBE: begin
            if (job_done || job_fail) begin
               state_nxt = pcs_pkg::ST_IDLE;
            end
         end
         pcs_pkg::ST_IDLE: begin
            if (reset_req_r) begin
               if ((cmd_r == pcs_pkg::CODE_SAVE_SAFE && !supply_low) ||
                   cmd_r == pcs_pkg::CODE_SAVE_ANY) begin
                  state_nxt = pcs_pkg::ST_SAVE;
                  start_ps = 1'b1;
               end else if ((cmd_r == pcs_pkg::CODE_DFLT_STD ||
                             cmd_r == pcs_pkg::CODE_DFLT_REG) && !drive_enabled) begin
                  state_nxt = pcs_pkg::ST_LOAD;
               end else if (np[3]) begin
                  state_nxt = pcs_pkg::ST_NP;
               end
               // Anything else cannot start or is unknown: command kept
            end else if (menu0_pend_r) begin
               state_nxt = pcs_pkg::ST_MENU0;
            end
         end
         pcs_pkg::ST_LOAD: begin
            if (job_fail) begin
               fail = 1'b1;
            end else if (job_done) begin
               state_nxt = pcs_pkg::ST_SAVE;
            end
         end
         pcs_pkg::ST_NP: begin
            if (job_fail) begin
               fail = 1'b1;
            end else if (job_done && job_dir) begin
               state_nxt = pcs_pkg::ST_SAVE;
            end else if (job_done) begin
               finish = 1'b1;
            end
         end
         pcs_pkg::ST_SAVE: begin
            if (job_fail) begin
               fail = 1'b1;
            end else if (job_done && (copy_r == pcs_pkg::COPY_CARD_LO ||
                                      copy_r == pcs_pkg::COPY_CARD_HI)) begin
               state_nxt = pcs_pkg::ST_CARD;
            end else if (job_done) begin
               finish = 1'b1;
            end
         end
         pcs_pkg::ST_CARD: begin
            if (job_fail) begin
               fail = 1'b1;
            end else if (job_done) begin
               finish = 1'b1;
            end
         end
         pcs_pkg::ST_MENU0: begin
            if (job_done || job_fail) begin
               state_nxt = pcs_pkg::ST_IDLE;
            end
         end
      endcase
      if (finish || fail) begin
         state_nxt = pcs_pkg::ST_IDLE;
      end
   end

   // State register; probe of the store runs first after reset
   always_ff @(posedge clock) begin
      if (reset) begin
         state_r <= pcs_pkg::ST_PROBE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Job request to the store; held until done or fail, no timeout
   always_ff @(posedge clock) begin
      if (reset) begin
         job_req <= 1'b1;
         job_code <= pcs_pkg::JOB_PROBE;
         job_bank <= 1'b0;
         job_ps <= 1'b0;
         job_clear <= 1'b0;
         job_direct <= 1'b0;
         job_slot <= 2'h0;
         job_dir <= 1'b0;
         ramp_volts <= pcs_pkg::RAMP_V_STD;
         rated_volts <= pcs_pkg::RATED_V_STD;
      end else if (state_nxt != state_r && state_nxt != pcs_pkg::ST_IDLE) begin
         job_req <= 1'b1;
         job_direct <= 1'b0;
         job_clear <= 1'b0;
         job_ps <= 1'b0;
         unique case (state_nxt)
            pcs_pkg::ST_LOAD: begin
               if (cmd_r == pcs_pkg::CODE_DFLT_REG && unit_400v) begin
                  job_code <= pcs_pkg::JOB_LOAD_REG;
                  ramp_volts <= pcs_pkg::RAMP_V_REGIONAL;
                  rated_volts <= pcs_pkg::RATED_V_REGIONAL;
               end else begin
                  job_code <= (cmd_r == pcs_pkg::CODE_DFLT_REG) ? pcs_pkg::JOB_LOAD_REG :
                              pcs_pkg::JOB_LOAD_STD;
                  ramp_volts <= pcs_pkg::RAMP_V_STD;
                  rated_volts <= pcs_pkg::RATED_V_STD;
               end
            end
            pcs_pkg::ST_NP: begin
               job_code <= pcs_pkg::JOB_NAMEPLATE;
               job_slot <= np[2:1];
               job_dir <= np[0];
            end
            pcs_pkg::ST_SAVE: begin
               job_code <= pcs_pkg::JOB_SAVE;
               job_bank <= ~active_bank;
               job_ps <= start_ps;
               job_clear <= (reinit_r != pcs_pkg::REINIT_RST);
            end
            pcs_pkg::ST_CARD: begin
               job_code <= pcs_pkg::JOB_CARD;
            end
            default: begin
               job_code <= pcs_pkg::JOB_SAVE;
               job_bank <= active_bank;
               job_direct <= 1'b1;
            end
         endcase
      end else if (job_done || job_fail) begin
         job_req <= 1'b0;
      end
   end

   // Active bank: from the probe, then switched by completed saves other than menu-0 saves
   always_ff @(posedge clock) begin
      if (reset) begin
         active_bank <= 1'b0;
      end else if (state_r == pcs_pkg::ST_PROBE && job_done && probe_bank_valid != 2'h0) begin
         active_bank <= probe_newest_bank;
      end else if (state_r == pcs_pkg::ST_SAVE && job_done) begin
         active_bank <= job_bank;
      end
   end

   // Pending keypad saves and bank re-initialisation count
   always_ff @(posedge clock) begin
      if (reset) begin
         menu0_pend_r <= 1'b0;
         reinit_r <= pcs_pkg::REINIT_RST;
      end else begin
         if (menu0_save_req) begin
            menu0_pend_r <= 1'b1;
         end else if (state_nxt == pcs_pkg::ST_MENU0) begin
            menu0_pend_r <= 1'b0;
         end
         if (module_change) begin
            reinit_r <= pcs_pkg::REINIT_SAVES;
         end else if (state_r == pcs_pkg::ST_SAVE && job_done && reinit_r != 2'h0) begin
            reinit_r <= reinit_r - 2'h1;
         end
      end
   end

   // Trips: sticky, set wins over a software clear
   always_ff @(posedge clock) begin
      if (reset) begin
         user_save_error_trip <= 1'b0;
         powerdown_save_error_trip <= 1'b0;
         store_invalid_trip <= 1'b0;
         action_fail_trip <= 1'b0;
      end else begin
         if (state_r == pcs_pkg::ST_PROBE && job_done && probe_torn_user) begin
            user_save_error_trip <= 1'b1;
         end else if (wr_take && avm_address == pcs_pkg::REG_STATUS &&
                      avm_writedata[pcs_pkg::ST_USER_ERR]) begin
            user_save_error_trip <= 1'b0;
         end
         if (state_r == pcs_pkg::ST_PROBE && job_done && probe_torn_pd) begin
            powerdown_save_error_trip <= 1'b1;
         end else if (wr_take && avm_address == pcs_pkg::REG_STATUS &&
                      avm_writedata[pcs_pkg::ST_PD_ERR]) begin
            powerdown_save_error_trip <= 1'b0;
         end
         if (state_r == pcs_pkg::ST_PROBE && (job_fail ||
             (job_done && probe_bank_valid == 2'h0))) begin
            store_invalid_trip <= 1'b1;
         end else if (wr_take && avm_address == pcs_pkg::REG_STATUS &&
                      avm_writedata[pcs_pkg::ST_INVALID]) begin
            store_invalid_trip <= 1'b0;
         end
         if (fail || (state_r == pcs_pkg::ST_MENU0 && job_fail)) begin
            action_fail_trip <= 1'b1;
         end else if (wr_take && avm_address == pcs_pkg::REG_STATUS &&
                      avm_writedata[pcs_pkg::ST_FAIL]) begin
            action_fail_trip <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Avalon-MM slave
   // ------------------------------------------------------------------
   // One wait state per access; write and read data at the low cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         avm_waitrequest <= 1'b1;
         avm_readdata <= 32'h00000000;
      end else begin
         avm_waitrequest <= !((avm_read || avm_write) && avm_waitrequest);
         if (rd_take) begin
            unique case (avm_address)
               pcs_pkg::REG_CMD: avm_readdata <= {15'h0000, cmd_r};
               pcs_pkg::REG_COPY: avm_readdata <= {29'h00000000, copy_r};
               pcs_pkg::REG_CTRL: avm_readdata <= {31'h00000000, !idle};
               pcs_pkg::REG_STATUS: avm_readdata <= {23'h000000, reinit_r, display_filter,
                  active_bank, action_fail_trip, store_invalid_trip,
                  powerdown_save_error_trip, user_save_error_trip};
               default: avm_readdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Command, copy mode, filter and drive-reset request
   always_ff @(posedge clock) begin
      if (reset) begin
         cmd_r <= pcs_pkg::CMD_RST;
         copy_r <= pcs_pkg::COPY_RST;
         display_filter <= pcs_pkg::FILT_ALL;
         reset_req_r <= 1'b0;
      end else begin
         if (finish) begin
            cmd_r <= pcs_pkg::CMD_RST;
            if (copy_r < pcs_pkg::COPY_CARD_LO) begin
               copy_r <= pcs_pkg::COPY_RST;
            end
         end else if (wr_take && idle && avm_address == pcs_pkg::REG_CMD) begin
            cmd_r <= avm_writedata[16:0];
            if (avm_writedata[16:0] == pcs_pkg::CODE_SHOW_NONDEF) begin
               display_filter <= pcs_pkg::FILT_NONDEF;
            end else if (avm_writedata[16:0] == pcs_pkg::CODE_SHOW_DESTINATION_CLASH_TRIP) begin
               display_filter <= pcs_pkg::FILT_DESTINATION_CLASH_TRIP;
            end else begin
               display_filter <= pcs_pkg::FILT_ALL;
            end
         end else if (wr_take && idle && avm_address == pcs_pkg::REG_COPY) begin
            copy_r <= avm_writedata[2:0];
         end
         if (wr_take && idle && avm_address == pcs_pkg::REG_CTRL &&
             avm_writedata[pcs_pkg::CTRL_RESET_BIT]) begin
            reset_req_r <= 1'b1;
         end else if (go) begin
            reset_req_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   sequence s_load_ok;
      state_r == pcs_pkg::ST_LOAD && job_done && !job_fail;
   endsequence
   sequence s_user_save;
      job_req && job_code == pcs_pkg::JOB_SAVE && !job_ps && !job_direct;
   endsequence

   property p_clear_cmd;
      finish |=> cmd_r == pcs_pkg::CMD_RST && idle;
   endproperty
   a_clear_cmd: assert property (p_clear_cmd) else $error("command not cleared");
   property p_not_started;
      go && state_nxt == pcs_pkg::ST_IDLE |=> $stable(cmd_r) && !$rose(action_fail_trip);
   endproperty
   a_not_started: assert property (p_not_started) else $error("refused action changed state");
   property p_fail_trip;
      fail |=> action_fail_trip && $stable(cmd_r) ##1 ($stable(cmd_r) || $past(wr_take));
   endproperty
   a_fail_trip: assert property (p_fail_trip) else $error("failure without trip");
   property p_copy_clear;
      finish |=> (copy_r == 3'h0) || ($past(copy_r) >= 3'h3 && copy_r == $past(copy_r));
   endproperty
   a_copy_clear: assert property (p_copy_clear) else $error("copy mode wrongly handled");
   property p_card_follow;
      state_r == pcs_pkg::ST_SAVE && job_done && (copy_r == 3'h3 || copy_r == 3'h4)
         |=> job_req && job_code == pcs_pkg::JOB_CARD;
   endproperty
   a_card_follow: assert property (p_card_follow) else $error("card write missing");
   property p_load_then_save;
      s_load_ok |=> s_user_save;
   endproperty
   a_load_then_save: assert property (p_load_then_save) else $error("no save after defaults");
   property p_safe_save;
      go && cmd_r == 17'h003e8 && supply_low |=> idle && !job_req;
   endproperty
   a_safe_save: assert property (p_safe_save) else $error("save started on low supply");
   property p_full_save;
      go && cmd_r == 17'h003e9 |=> job_req && job_code == pcs_pkg::JOB_SAVE && job_ps;
   endproperty
   a_full_save: assert property (p_full_save) else $error("commanded save lacks pd set");
   property p_bank_swap;
      state_r == pcs_pkg::ST_SAVE && job_done |=> active_bank == $past(job_bank);
   endproperty
   a_bank_swap: assert property (p_bank_swap) else $error("bank not committed");
   property p_inactive_bank;
      state_r == pcs_pkg::ST_SAVE |-> job_bank != active_bank;
   endproperty
   a_inactive_bank: assert property (p_inactive_bank) else $error("save into active bank");
   property p_direct_bank;
      state_r == pcs_pkg::ST_MENU0 |-> job_direct && job_bank == active_bank;
   endproperty
   a_direct_bank: assert property (p_direct_bank) else $error("menu-0 save not direct");
   property p_invalid;
      state_r == pcs_pkg::ST_PROBE && job_done && probe_bank_valid == 2'h0
         |=> store_invalid_trip;
   endproperty
   a_invalid: assert property (p_invalid) else $error("invalid store not tripped");
endmodule

/* pcs_store_model.sv */
// Behavioural parameter store and card answering the engine's job link
`timescale 1ns/1ns
module pcs_store_model (
   input wire logic clock,
   input wire logic reset,
   input wire logic job_req,
   input wire logic fail_mode,
   input wire logic probe_mode,
   output logic job_done,
   output logic job_fail,
   output logic [1:0] probe_bank_valid,
   output logic probe_newest_bank,
   output logic probe_torn_user,
   output logic probe_torn_pd
);
   logic [3:0] wait_r;
   logic seen_r;
   // -------------------------------------------------------------
   // Job answer
   // -------------------------------------------------------------
   // One pulse per job after ten cycles, only while a job is asked
   always_ff @(posedge clock) begin
      job_done <= 1'b0;
      job_fail <= 1'b0;
      if (reset || !job_req || job_done || job_fail) begin
         seen_r <= 1'b0;
         wait_r <= 4'h0;
      end else if (!seen_r) begin
         wait_r <= wait_r + 4'h1;
         if (wait_r == 4'h9) begin
            seen_r <= 1'b1;
            job_done <= !fail_mode;
            job_fail <= fail_mode;
         end
      end
   end
   // Normal store: both banks valid, bank 0 newest; damaged store: no valid bank, torn saves
   assign probe_bank_valid = probe_mode ? 2'h0 : 2'h3;
   assign probe_newest_bank = 1'b0;
   assign probe_torn_user = probe_mode;
   assign probe_torn_pd = probe_mode;
endmodule

/* pcs_engine_bench.sv */
// Self-checking bench for the parameter command and save engine
`timescale 1ns/1ns
module pcs_engine_bench;
   logic clock = 0, reset = 1, rd_r, wr_r, uv = 0, en = 0, v4 = 1, fm = 0, done, fail, newest;
   logic tu, tp, jreq, jbank, jps, abank, wait_n, jclr, jdirect, jdir, aft;
   logic ls = 0, m0 = 0, mc = 0, pm = 0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, q;
   logic [1:0] valid, filt, jslot;
   logic [2:0] jcode;
   logic [9:0] ramp, rated;
   int n_fail = 0, comparisons = 0;
   initial rd_r = 0;
   initial wr_r = 0;
   always #4 clock = !clock;
   pcs_engine i_dut (.clock(clock), .reset(reset), .avm_address(addr), .avm_read(rd_r),
      .avm_write(wr_r), .avm_writedata(wdata), .avm_readdata(rdata), .avm_waitrequest(wait_n),
      .undervoltage_pin(uv), .low_supply_pin(ls), .drive_enabled_pin(en), .unit_400v_pin(v4),
      .menu0_save_req(m0), .module_change(mc), .job_done(done), .job_fail(fail),
      .probe_bank_valid(valid), .probe_newest_bank(newest), .probe_torn_user(tu),
      .probe_torn_pd(tp), .job_req(jreq), .job_code(jcode), .job_bank(jbank), .job_ps(jps),
      .job_clear(jclr), .job_direct(jdirect), .job_slot(jslot), .job_dir(jdir),
      .ramp_volts(ramp), .rated_volts(rated), .display_filter(filt), .active_bank(abank),
      .user_save_error_trip(), .powerdown_save_error_trip(), .store_invalid_trip(),
      .action_fail_trip(aft));
   pcs_store_model i_store (.clock(clock), .reset(reset), .job_req(jreq), .fail_mode(fm),
      .probe_mode(pm),
      .job_done(done), .job_fail(fail), .probe_bank_valid(valid), .probe_newest_bank(newest),
      .probe_torn_user(tu), .probe_torn_pd(tp));
   // -------------------------------------------------------------
   // Bus and compare tasks
   // -------------------------------------------------------------
   // Hold the request until waitrequest is seen low, then release
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      addr <= a;
      wdata <= d;
      wr_r <= w;
      rd_r <= !w;
      @(posedge clock);
      while (wait_n !== 1'b0 && n < 50) begin
         @(posedge clock);
         n++;
      end
      if (n == 50) n_fail++;
      q = rdata;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      @(posedge clock);
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk("register", e, q & m);
   endtask
   // Poll busy until the engine is idle again
   task automatic idle();
      int n;
      n = 0;
      q = 32'h1;
      while (q[0] !== 1'b0 && n < 100) begin
         bus(1'b0, 4'h8, 32'h0);
         n++;
      end
      if (n == 100) n_fail++;
   endtask
   // Write a command, request a drive reset, let the job start
   task automatic go(input logic [31:0] c);
      bus(1'b1, 4'h0, c);
      bus(1'b1, 4'h8, 32'h1);
      repeat (3) @(posedge clock);
   endtask
   task automatic results();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #400000;
      n_fail++;
      results();
   end
   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      idle();
      go(32'h3e9);
      chk("job_ps", 1, jps);
      chk("job_bank", 1, jbank);
      chk("active_bank", 0, abank);
      idle();
      chk("active_bank", 1, abank);
      rchk(4'h0, 32'h1ffff, 32'h0);
      uv <= 1'b1;
      repeat (4) @(posedge clock);
      go(32'h3e8);
      chk("job_req", 0, jreq);
      rchk(4'h0, 32'h1ffff, 32'h3e8);
      rchk(4'hc, 32'hf, 32'h0);
      uv <= 1'b0;
      ls <= 1'b1;
      repeat (4) @(posedge clock);
      go(32'h3e8);
      chk("job_req", 0, jreq);
      ls <= 1'b0;
      repeat (4) @(posedge clock);
      bus(1'b1, 4'h4, 32'h2);
      go(32'h3e8);
      chk("job_code", 1, jcode);
      idle();
      rchk(4'h0, 32'h1ffff, 32'h0);
      rchk(4'h4, 32'h7, 32'h0);
      en <= 1'b1;
      repeat (4) @(posedge clock);
      go(32'h4d1);
      chk("job_req", 0, jreq);
      rchk(4'h0, 32'h1ffff, 32'h4d1);
      en <= 1'b0;
      repeat (4) @(posedge clock);
      go(32'h4dc);
      chk("volts", 32'h307, ramp);
      chk("volts", 32'h1cc, rated);
      idle();
      rchk(4'h0, 32'h1ffff, 32'h0);
      fm <= 1'b1;
      go(32'h3e9);
      idle();
      rchk(4'hc, 32'h8, 32'h8);
      chk("trip", 1, aft);
      rchk(4'h0, 32'h1ffff, 32'h3e9);
      fm <= 1'b0;
      bus(1'b1, 4'h0, 32'h2ee0);
      chk("filter", 1, filt);
      bus(1'b1, 4'h0, 32'h2ee1);
      chk("filter", 2, filt);
      go(32'h3e7);
      chk("job_req", 0, jreq);
      rchk(4'h0, 32'h1ffff, 32'h3e7);
      rchk(4'h2, 32'hffffffff, 32'h0);
      {m0, mc} <= 2'h3;
      @(posedge clock);
      {m0, mc} <= 2'h0;
      repeat (3) @(posedge clock);
      chk("job_direct", 1, jdirect);
      chk("job_bank", 1, jbank);
      idle();
      go(32'h3e9);
      chk("job_clear", 1, jclr);
      idle();
      rchk(4'hc, 32'h180, 32'h80);
      go(32'h2b0d);
      chk("job_slot", 2, jslot);
      chk("job_dir", 1, jdir);
      idle();
      rchk(4'h0, 32'h1ffff, 32'h0);
      bus(1'b1, 4'h4, 32'h3);
      go(32'h3e9);
      idle();
      rchk(4'h4, 32'h7, 32'h3);
      rchk(4'h0, 32'h1ffff, 32'h0);
      // Second reset with a damaged store behind the engine
      pm <= 1'b1;
      reset <= 1'b1;
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      idle();
      rchk(4'hc, 32'h1f, 32'h7);
      results();
   end
endmodule
